// *** verilog/gpab_defs.svh ***
`ifndef GPAB_DEFS_SVH
`define GPAB_DEFS_SVH

// ----------------------------------------------------------------
// port geometry
// ----------------------------------------------------------------
`define GPAB_PORT_COUNT 10
`define GPAB_PORT_W 16
`define GPAB_PORT_C_W 5
`define GPAB_PORT_D_W 14
`define GPAB_PORT_G_W 4

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPAB_A_DATA_IDX 32'hfffff726
`define GPAB_B_DATA_IDX 32'hfffff738
`define GPAB_A_DIR_IDX 32'hfffff7f0
`define GPAB_B_DIR_IDX 32'hfffff7f1
`define GPAB_A_FUNC_IDX 32'hfffff7f2
`define GPAB_B_FUNC_IDX 32'hfffff7f3

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define GPAB_DATA_RST 16'h0000
`define GPAB_DIR_RST 16'h0000
`define GPAB_FUNC_RST 16'h0000
`define GPAB_LO_BYTE 7:0
`define GPAB_HI_BYTE 15:8

// ----------------------------------------------------------------
// bus timing
// ----------------------------------------------------------------
`define GPAB_ACCESS_CYCLES 4
`define GPAB_WAIT_LAST 2'h1

`endif

// *** verilog/gpab_pkg.sv ***
package gpab_pkg;

    // ------------------------------------------------------------
    // pin drive seen from the pad ring
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] out;  // level driven when enabled
        logic [15:0] oe;   // high while the pin is driven
    } gpab_pin_t;

    // ------------------------------------------------------------
    // register selected by the bus address
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GPAB_SEL_NONE,
        GPAB_SEL_DATA,
        GPAB_SEL_DIR,
        GPAB_SEL_FUNC
    } gpab_sel_t;

    // decoded address: which register and which port
    typedef struct packed {
        gpab_sel_t sel;
        logic port;        // 0 = port a, 1 = port b
    } gpab_dec_t;

    // bus handshake state
    typedef enum logic [1:0] {
        GPAB_IDLE,
        GPAB_WAIT,
        GPAB_DONE
    } gpab_bus_state_t;

endpackage

// *** verilog/gpab_port_data.sv ***
`timescale 1ns/100ps
`include "gpab_defs.svh"
// Summary of operation
// - ten ports exist; this block serves a, b
// - ports a and b are sixteen pins
// - each pin is gpio or peripheral function
// - each port owns a data register
// - data register access takes four cycles
// - port a data: 16 bits, bit n = pin n
// - port b data: 16 bits, bit n = pin n
// - dir 1 gpio: write drives pin, read register
// - dir 0 gpio: read pin, write only stored
// - dir 0 peripheral: read pin, write stored
// - dir 1 peripheral: read register, pin unaffected
// - power-on reset and hw standby clear data
// - data kept through sleep and soft standby
module gpab_port_data
    import gpab_pkg::*;
#(
    parameter int PORT_W = `GPAB_PORT_W,
    parameter int ACCESS_CYCLES = `GPAB_ACCESS_CYCLES
)
(
    // clock and power-on reset
    input wire logic mclk,
    input wire logic rst_b,
    // hardware standby level from the pad
    input wire logic hw_standby,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral side of the shared pins
    input wire gpab_pin_t periph_a,
    input wire gpab_pin_t periph_b,
    // pad side
    input wire logic [15:0] port_a_pin_in,
    input wire logic [15:0] port_b_pin_in,
    output gpab_pin_t port_a_pins,
    output gpab_pin_t port_b_pins
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // byte address of a register index
    function automatic logic [31:0] idx_addr(input logic [31:0] idx);
        idx_addr = {idx[29:0], 2'h0};
    endfunction

    // address decode, shared by every access
    function automatic gpab_dec_t decode(input logic [31:0] addr);
        decode.sel = GPAB_SEL_NONE;
        decode.port = 1'b0;
        if (addr == idx_addr(`GPAB_A_DATA_IDX))
        begin
            decode.sel = GPAB_SEL_DATA;
        end
        else if (addr == idx_addr(`GPAB_B_DATA_IDX))
        begin
            decode.sel = GPAB_SEL_DATA;
            decode.port = 1'b1;
        end
        else if (addr == idx_addr(`GPAB_A_DIR_IDX))
        begin
            decode.sel = GPAB_SEL_DIR;
        end
        else if (addr == idx_addr(`GPAB_B_DIR_IDX))
        begin
            decode.sel = GPAB_SEL_DIR;
            decode.port = 1'b1;
        end
        else if (addr == idx_addr(`GPAB_A_FUNC_IDX))
        begin
            decode.sel = GPAB_SEL_FUNC;
        end
        else if (addr == idx_addr(`GPAB_B_FUNC_IDX))
        begin
            decode.sel = GPAB_SEL_FUNC;
            decode.port = 1'b1;
        end
    endfunction

    // merge write data under the two low byte strobes
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        merge = old;
        if (strb[0])
        begin
            merge[`GPAB_LO_BYTE] = wdata[`GPAB_LO_BYTE];
        end
        if (strb[1])
        begin
            merge[`GPAB_HI_BYTE] = wdata[`GPAB_HI_BYTE];
        end
    endfunction

    // ------------------------------------------------------------
    // pad input synchronisers
    // ------------------------------------------------------------
    logic [15:0] pin_meta_reg [2];  // first stage, read by stage two only
    logic [15:0] pin_sync_reg [2];  // safe pin level
    logic stby_meta_reg;  // standby first stage
    logic stby_sync_reg;  // standby, clean

    // two flops per pad bit; pins are asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta_reg[0] <= 16'h0000;
            pin_meta_reg[1] <= 16'h0000;
            pin_sync_reg[0] <= 16'h0000;
            pin_sync_reg[1] <= 16'h0000;
            stby_meta_reg <= 1'b0;
            stby_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg[0] <= port_a_pin_in;
            pin_meta_reg[1] <= port_b_pin_in;
            pin_sync_reg[0] <= pin_meta_reg[0];
            pin_sync_reg[1] <= pin_meta_reg[1];
            stby_meta_reg <= hw_standby;
            stby_sync_reg <= stby_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    gpab_bus_state_t state_reg;  // handshake phase
    gpab_bus_state_t state_next;
    logic [1:0] wait_reg;  // access-phase cycles spent
    logic [1:0] wait_next;
    logic [31:0] prdata_next;
    logic pready_next;
    logic pslverr_next;
    logic commit;  // the cycle in which the answer is built
    gpab_dec_t dec;  // decode of the held address

    // each port a data register
    logic [15:0] data_reg [2];
    logic [15:0] data_next [2];
    logic [15:0] dir_reg [2];  // direction, 1 = output
    logic [15:0] dir_next [2];
    logic [15:0] func_reg [2];  // 1 = pin lent to peripheral
    logic [15:0] func_next [2];

    // read mux per pin: register when output, pad when input
    function automatic logic [15:0] read_view(
        input logic [15:0] data,
        input logic [15:0] dir,
        input logic [15:0] pin
    );
        read_view = (data & dir) | (pin & ~dir);
    endfunction

    // wait states stretch the transfer to four cycles in all;
    // sizes do not matter, byte and halfword cost the same
    always_comb
    begin
        dec = decode(paddr);
        state_next = state_reg;
        wait_next = wait_reg;
        prdata_next = prdata;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        commit = 1'b0;
        case (state_reg)
            GPAB_IDLE:
            begin
                // access phase opens: start counting
                if (psel && penable)
                begin
                    state_next = GPAB_WAIT;
                    wait_next = 2'h1;
                end
                else
                begin
                    wait_next = 2'h0;
                end
            end
            GPAB_WAIT:
            begin
                // last wait cycle: answer appears next edge
                if (wait_reg == `GPAB_WAIT_LAST)
                begin
                    commit = 1'b1;
                    state_next = GPAB_DONE;
                    pready_next = 1'b1;
                    pslverr_next = (dec.sel == GPAB_SEL_NONE);
                    prdata_next = 32'h0000_0000;
                    if (!pwrite)
                    begin
                        case (dec.sel)
                            GPAB_SEL_DATA:
                            begin
                                prdata_next[15:0] = read_view(
                                    data_reg[dec.port],
                                    dir_reg[dec.port],
                                    pin_sync_reg[dec.port]);
                            end
                            GPAB_SEL_DIR:
                            begin
                                prdata_next[15:0] = dir_reg[dec.port];
                            end
                            GPAB_SEL_FUNC:
                            begin
                                prdata_next[15:0] = func_reg[dec.port];
                            end
                            default:
                            begin
                                prdata_next = 32'h0000_0000;
                            end
                        endcase
                    end
                end
                else
                begin
                    wait_next = wait_reg + 2'h1;
                end
            end
            GPAB_DONE:
            begin
                // pready seen by master this edge; back to idle
                state_next = GPAB_IDLE;
                wait_next = 2'h0;
            end
            default:
            begin
                state_next = GPAB_IDLE;
                wait_next = 2'h0;
            end
        endcase
    end

    // handshake registers; outputs leave straight from flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= GPAB_IDLE;
            wait_reg <= 2'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------

    // writes land with the answer; standby wipes data only.
    // a watchdog reset never reaches rst_b, so data survives it,
    // and sleep or soft standby have no path here at all
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            data_next[p] = data_reg[p];
            dir_next[p] = dir_reg[p];
            func_next[p] = func_reg[p];
            if (commit && pwrite && dec.port == p[0])
            begin
                case (dec.sel)
                    GPAB_SEL_DATA:
                    begin
                        // always stored, whatever the pin mode
                        data_next[p] = merge(data_reg[p], pwdata,
                            pstrb);
                    end
                    GPAB_SEL_DIR:
                    begin
                        dir_next[p] = merge(dir_reg[p], pwdata, pstrb);
                    end
                    GPAB_SEL_FUNC:
                    begin
                        func_next[p] = merge(func_reg[p], pwdata, pstrb);
                    end
                    default:
                    begin
                        data_next[p] = data_reg[p];
                    end
                endcase
            end
            if (stby_sync_reg)
            begin
                data_next[p] = `GPAB_DATA_RST;
            end
        end
    end

    // storage; power-on reset clears everything
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int p = 0; p < 2; p++)
            begin
                data_reg[p] <= `GPAB_DATA_RST;
                dir_reg[p] <= `GPAB_DIR_RST;
                func_reg[p] <= `GPAB_FUNC_RST;
            end
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                data_reg[p] <= data_next[p];
                dir_reg[p] <= dir_next[p];
                func_reg[p] <= func_next[p];
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    gpab_pin_t pins_next [2];  // drive computed per port
    gpab_pin_t periph [2];  // peripheral request per port

    // peripheral pins follow the peripheral; gpio pins follow
    // data and direction. one flop of latency on every pin
    always_comb
    begin
        periph[0] = periph_a;
        periph[1] = periph_b;
        for (int p = 0; p < 2; p++)
        begin
            pins_next[p].out = (periph[p].out & func_reg[p])
                | (data_reg[p] & ~func_reg[p]);
            pins_next[p].oe = (periph[p].oe & func_reg[p])
                | (dir_reg[p] & ~func_reg[p]);
        end
    end

    // pad drive registers; all pins released under reset
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_a_pins <= '0;
            port_b_pins <= '0;
        end
        else
        begin
            port_a_pins <= pins_next[0];
            port_b_pins <= pins_next[1];
        end
    end

    // ports c..k live elsewhere; geometry kept in the defs header
    // so the other port blocks share it
    logic unused_geom;
    assign unused_geom = (PORT_W == `GPAB_PORT_W)
        && (ACCESS_CYCLES == `GPAB_ACCESS_CYCLES);

endmodule

// *** bench/gpab_pad_model.sv ***
`timescale 1ns/100ps
module gpab_pad_model
    import gpab_pkg::*;
(
    // drive from the block
    input wire gpab_pin_t port_a_pins,
    input wire gpab_pin_t port_b_pins,
    // board level on undriven pins
    input wire logic [15:0] ext_a,
    input wire logic [15:0] ext_b,
    // level seen back at the block
    output logic [15:0] port_a_pin_in,
    output logic [15:0] port_b_pin_in
);
    // ------------------------------------------------------------
    // pad resolution
    // ------------------------------------------------------------
    // a driven pin shows the block's level, so a read-back of a
    // driven input bit would hide a wrong select in the block
    assign port_a_pin_in = (port_a_pins.oe & port_a_pins.out)
        | (~port_a_pins.oe & ext_a);
    assign port_b_pin_in = (port_b_pins.oe & port_b_pins.out)
        | (~port_b_pins.oe & ext_b);
endmodule

// *** bench/gpab_port_data_checker.sv ***
`timescale 1ns/100ps
module gpab_port_data_checker
    import gpab_pkg::*;
#(
    parameter int PORT_W = 16,
    parameter int ACCESS_CYCLES = 4
)
(
    // clock and resets
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hw_standby,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire gpab_pin_t periph_a,
    input wire gpab_pin_t periph_b,
    input wire logic [15:0] port_a_pin_in,
    input wire logic [15:0] port_b_pin_in,
    input wire gpab_pin_t port_a_pins,
    input wire gpab_pin_t port_b_pins
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // quiet counter: cycles since anything could move the pins
    // ------------------------------------------------------------
    logic [2:0] quiet_reg, quiet_next;
    logic [63:0] per_reg;
    logic hit;
    // write, standby or peripheral change restarts the count
    always_comb
    begin
        quiet_next = quiet_reg;
        if ((pready && pwrite) || hw_standby
            || {periph_a, periph_b} != per_reg)
            quiet_next = 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_next = quiet_reg + 3'h1;
    end
    // registers only
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            quiet_reg <= 3'h0;
            per_reg <= 64'h0;
        end
        else
        begin
            quiet_reg <= quiet_next;
            per_reg <= {periph_a, periph_b};
        end
    end
    // mapped byte addresses
    assign hit = paddr inside {32'hffffdc98, 32'hffffdce0, 32'hffffdfc0,
        32'hffffdfc4, 32'hffffdfc8, 32'hffffdfcc};
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_fourth: assert property (
        psel && !penable |-> (!pready)[*3] ##1 pready)
        else $error("pready not in fourth cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (
        pready && !hit |-> pslverr)
        else $error("no error on unmapped address");
    a_no_err_mapped: assert property (
        pready && hit |-> !pslverr && psel && penable)
        else $error("bad answer on mapped address");
    a_read_unmapped: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !pready |-> $stable(prdata) && prdata[31:16] == 16'h0)
        else $error("read data moved between answers");
    a_reset_idle: assert property (
        $rose(rst_b) |-> !pready && port_a_pins == 32'h0
        && port_b_pins == 32'h0)
        else $error("outputs not idle after reset");
    a_pins_quiet: assert property (
        quiet_reg >= 3'h5 && {periph_a, periph_b} == per_reg
        |-> $stable(port_a_pins) && $stable(port_b_pins))
        else $error("pins moved without cause");
endmodule

bind gpab_port_data gpab_port_data_checker #(.PORT_W(PORT_W),
    .ACCESS_CYCLES(ACCESS_CYCLES)) u_chk (.mclk(mclk), .rst_b(rst_b),
    .hw_standby(hw_standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_a(periph_a), .periph_b(periph_b),
    .port_a_pin_in(port_a_pin_in), .port_b_pin_in(port_b_pin_in),
    .port_a_pins(port_a_pins), .port_b_pins(port_b_pins));

// *** bench/gpab_port_data_tb_top.sv ***
`timescale 1ns/100ps
module gpab_port_data_tb_top
    import gpab_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk = 1'b0, rst_b = 1'b0, hw_standby = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'h0;
    gpab_pin_t periph_a = '0, periph_b = '0, port_a_pins, port_b_pins;
    logic [15:0] port_a_pin_in, port_b_pin_in, rd_v;
    logic [15:0] ext_a = 16'h5a3c, ext_b = 16'hc3a5; // board levels
    logic er_v;
    int mismatches = 0, num_checks = 0, cyc = 0;
    // byte addresses, four times the register index
    localparam logic [31:0] A_DAT = 32'hffffdc98, B_DAT = 32'hffffdce0;
    localparam logic [31:0] A_DIR = 32'hffffdfc0, B_DIR = 32'hffffdfc4;
    localparam logic [31:0] A_FUN = 32'hffffdfc8, B_FUN = 32'hffffdfcc;

    gpab_port_data dut (.mclk(mclk), .rst_b(rst_b),
        .hw_standby(hw_standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_a(periph_a), .periph_b(periph_b),
        .port_a_pin_in(port_a_pin_in), .port_b_pin_in(port_b_pin_in),
        .port_a_pins(port_a_pins), .port_b_pins(port_b_pins));
    gpab_pad_model u_pads (.port_a_pins(port_a_pins),
        .port_b_pins(port_b_pins), .ext_a(ext_a), .ext_b(ext_b),
        .port_a_pin_in(port_a_pin_in), .port_b_pin_in(port_b_pin_in));

    // 100 MHz
    always #5 mclk = ~mclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one transfer; called just after an edge, psel left high for
    // a following setup, so every run of transfers ends in idle
    task automatic apb(input logic wr, input logic [31:0] a, d,
        input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        // hold everything until pready is seen at a rising edge;
        // only the bench timeout ends a slave that never answers
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd_v = prdata[15:0];
        er_v = pslverr;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'h3);
        apb(1'b1, a, d, s);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a,
        input logic [15:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        check(what, rd_v, exp);
    endtask
    task automatic idle;
        psel <= 1'b0;
        @(posedge mclk);
    endtask
    // pin drive, out compared only where driven
    task automatic pin_chk(input gpab_pin_t p, input logic [15:0] o, e);
        check("pin oe", p.oe, e);
        check("pin out", p.out & e, o & e);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd_chk("a in", A_DAT, 16'h5a3c);
        rd_chk("b dir", B_DIR, 16'h0);
        wr(A_DIR, 32'hffff);
        rd_chk("a reset", A_DAT, 16'h0);
        idle;
    endtask
    task automatic t_bytes;
        wr(A_DAT, 32'ha5c3);
        rd_chk("a out", A_DAT, 16'ha5c3);
        wr(A_DAT, 32'h7700, 4'h2);
        rd_chk("a hi", A_DAT, 16'h77c3);
        wr(A_DAT, 32'h0011, 4'h1);
        wr(A_DAT, 32'hffff, 4'h0);
        rd_chk("a lo", A_DAT, 16'h7711);
        idle;
        @(negedge mclk);
        pin_chk(port_a_pins, 16'h7711, 16'hffff);
        @(posedge mclk);
    endtask
    task automatic t_input;
        wr(A_DIR, 32'h00ff);
        wr(A_DAT, 32'h1234);
        rd_chk("a mixed", A_DAT, 16'h5a34);
        idle;
        @(negedge mclk);
        pin_chk(port_a_pins, 16'h1234, 16'h00ff);
        @(posedge mclk);
    endtask
    task automatic t_periph;
        periph_b <= '{out: 16'h0f0f, oe: 16'hffff};
        periph_a <= '{out: 16'h00a0, oe: 16'h00f0};
        wr(A_FUN, 32'h00f0);
        rd_chk("a func", A_FUN, 16'h00f0);
        rd_chk("a lent", A_DAT, 16'h5a34);
        wr(B_FUN, 32'hffff);
        wr(B_DIR, 32'hff00);
        wr(B_DAT, 32'hbeef);
        rd_chk("b periph", B_DAT, 16'hbe0f);
        idle;
        @(negedge mclk);
        pin_chk(port_b_pins, 16'h0f0f, 16'hffff);
        pin_chk(port_a_pins, 16'h00a4, 16'h00ff);
        @(posedge mclk);
    endtask
    task automatic t_unmapped;
        wr(32'h10, 32'hffff);
        check("wr err", {15'h0, er_v}, 16'h1);
        rd_chk("unmapped", 32'h10, 16'h0);
        check("rd err", {15'h0, er_v}, 16'h1);
        rd_chk("b kept", B_DAT, 16'hbe0f);
        idle;
    endtask
    task automatic t_standby;
        wr(A_DIR, 32'hffff);
        idle;
        hw_standby <= 1'b1;
        repeat (6) @(posedge mclk);
        hw_standby <= 1'b0;
        repeat (3) @(posedge mclk);
        rd_chk("a standby", A_DAT, 16'h0);
        wr(A_DAT, 32'h1357);
        idle;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd_chk("dir reset", A_DIR, 16'h0);
        wr(A_DIR, 32'hffff);
        rd_chk("data reset", A_DAT, 16'h0);
        idle;
    endtask
    // ------------------------------------------------------------
    // verdict and hang guard
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            end_sim;
        end
    end
    // main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_bytes;
        t_input;
        t_periph;
        t_unmapped;
        t_standby;
        end_sim;
    end
endmodule
